// ===== rtl/lks_defs.svh
`ifndef LKS_DEFS_SVH
`define LKS_DEFS_SVH

// system clock rate and the one-second tick
`define LKS_CLK_HZ          50000000
`define LKS_TICK_S          1
`define LKS_TICK_CYCLES     (`LKS_TICK_S * `LKS_CLK_HZ)

// serial prefix for data coming from the network sockets
`define LKS_HDR_B0          8'haa
`define LKS_HDR_B1          8'hfe
`define LKS_HDR_B2          8'h55
`define LKS_HDR_SOCK0       8'h00
`define LKS_HDR_SOCK1       8'h01

// interval limits and reset values, in seconds
`define LKS_RESTART_DEF_S   16'h0708
`define LKS_RESTART_MIN_S   16'h003c
`define LKS_SHORT_MIN_S     16'h0001

// pre-connection buffer limits
`define LKS_BUF_PKTS        1024
`define LKS_BUF_BYTES       10240

// heartbeat user content limit in bytes
`define LKS_HB_MAX_LEN      8'h80

`endif

// ===== rtl/lks_pkg.sv
package lks_pkg;

  // heartbeat content choice
  typedef enum logic [1:0] {
    LKS_HB_SERIAL_ID,
    LKS_HB_MAC,
    LKS_HB_USER
  } lks_hb_sel_t;

  // serial transmit path state
  typedef enum logic [1:0] {
    LKS_TX_IDLE,
    LKS_TX_HDR,
    LKS_TX_DATA
  } lks_tx_state_t;

endpackage : lks_pkg

// ===== rtl/lks_supervisor.sv
// Overview of operation
// - data from socket two goes to serial behind header aa fe 55 01
// - in client mode, lost link is retried at the reconnection interval
// - reconnection interval 0 to 65535 seconds; zero retries at once
// - with restart on, no network data for the timeout restarts the unit
// - restart timeout spans 60 to 65535 seconds, default 1800
// - short connection only in tcp or http client, off after reset
// - short connection opens the link only when data waits to be sent
// - open short link closes after idle time without serial or network traffic
// - short connection idle time spans 1 to 65535 seconds
// - client serial data is buffered while no link exists
// - full buffer overwrites its oldest entry with new serial data while unlinked in client mode
// - clear-on-connect discards serial data received before connection
// - without clear-on-connect, buffered data is forwarded once connected
// - serial heartbeat counts from serial idle, fires at its period
// - heartbeat content chosen as serial id, mac or user data, per heartbeat
// - user heartbeat content limited to 128 bytes, hex flag passed on
// - network heartbeats only in client mode, apart from any mqtt keepalive
// - each network link keeps its own heartbeat timer and content
// - network heartbeat starts at link up and fires every period
// - data from socket one goes to serial behind header aa fe 55 00

`include "lks_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// first-in first-out buffer with drop-oldest support

module lks_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             overwrite,
  // read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // housekeeping
  input  wire logic             flush,
  output logic                  full,
  output logic                  empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign full      = (count == (AW+1)'(DEPTH));
  assign empty     = (count == '0);
  assign in_ready  = !full || overwrite;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = (out_valid && out_ready) || (do_wr && full);

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule : lks_fifo

////////////////////////////////////////////////////////////////////////////////
// link supervisor top

module lks_supervisor
  import lks_pkg::*;
#(
  parameter int TICK_CYCLES = `LKS_TICK_CYCLES,
  parameter int BUF_DEPTH   = 8
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // configuration
  input  wire logic        client_mode,
  input  wire logic        tcp_http_client,
  input  wire logic [15:0] reconn_interval,
  input  wire logic        restart_en,
  input  wire logic [15:0] restart_period,
  input  wire logic        short_en,
  input  wire logic [15:0] short_time,
  input  wire logic        clear_on_connect,
  input  wire logic [15:0] ser_hb_period,
  input  wire lks_hb_sel_t ser_hb_sel,
  input  wire logic        ser_hb_hex,
  input  wire logic [7:0]  ser_hb_len,
  input  wire logic [31:0] net_hb_period,
  input  wire logic [3:0]  net_hb_sel,
  input  wire logic [1:0]  net_hb_hex,
  input  wire logic [15:0] net_hb_len,
  // link control
  input  wire logic [1:0]  link_up,
  input  wire logic        connect_fail,
  output logic             connect_req,
  output logic             disconnect_req,
  output logic             restart_req,
  // serial receive, toward the network
  input  wire logic        ser_rx_valid,
  output logic             ser_rx_ready,
  input  wire logic [7:0]  ser_rx_data,
  output logic             net_tx_valid,
  input  wire logic        net_tx_ready,
  output logic [7:0]       net_tx_data,
  // network receive, toward the serial port
  input  wire logic        sock_rx_valid,
  output logic             sock_rx_ready,
  input  wire logic [7:0]  sock_rx_data,
  input  wire logic        sock_rx_id,
  input  wire logic        sock_rx_last,
  output logic             ser_tx_valid,
  input  wire logic        ser_tx_ready,
  output logic [7:0]       ser_tx_data,
  // heartbeats
  output logic             ser_hb_req,
  output lks_hb_sel_t      ser_hb_sel_out,
  output logic             ser_hb_hex_out,
  output logic [7:0]       ser_hb_len_out,
  output logic [1:0]       net_hb_req,
  output logic [3:0]       net_hb_sel_out,
  output logic [1:0]       net_hb_hex_out,
  output logic [15:0]      net_hb_len_out
);

  ////////////////////////////////////////////////////////////////////////////
  // one-second tick

  logic [31:0] tick_cnt;
  logic        tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receive buffer

  logic link_any;
  logic short_mode;
  logic buf_full;
  logic buf_empty;
  logic buf_valid;
  logic buf_drop;
  logic link_rise;
  logic link_q;

  assign link_any   = link_up[0];
  assign short_mode = short_en && client_mode && tcp_http_client;
  assign buf_drop   = client_mode && !link_any && clear_on_connect;
  assign link_rise  = link_any && !link_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_any;
    end
  end

  logic fifo_in_ready;

  assign ser_rx_ready = buf_drop || fifo_in_ready;

  lks_fifo #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (ser_rx_valid && !buf_drop),
    .in_ready  (fifo_in_ready),
    .in_data   (ser_rx_data),
    .overwrite (client_mode && !link_any),
    .out_valid (buf_valid),
    .out_ready (net_tx_ready && link_any),
    .out_data  (net_tx_data),
    .flush     (link_rise && clear_on_connect),
    .full      (buf_full),
    .empty     (buf_empty)
  );

  assign net_tx_valid = buf_valid && link_any;

  ////////////////////////////////////////////////////////////////////////////
  // reconnection and short connection open

  logic [15:0] recon_cnt;
  logic        attempt;
  logic        want_link;
  logic        recon_due;

  assign want_link = client_mode && !link_any && (!short_mode || !buf_empty);
  assign recon_due = (reconn_interval == 16'h0) || (recon_cnt == 16'h0);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      recon_cnt   <= '0;
      attempt     <= 1'b0;
      connect_req <= 1'b0;
    end else begin
      connect_req <= 1'b0;
      if (!want_link || link_any) begin
        attempt   <= 1'b0;
        recon_cnt <= '0;
      end else if (attempt) begin
        if (connect_fail) begin
          attempt   <= 1'b0;
          recon_cnt <= reconn_interval;
        end
      end else if (recon_due) begin
        attempt     <= 1'b1;
        connect_req <= 1'b1;
      end else if (tick) begin
        recon_cnt <= recon_cnt - 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout restart

  logic [15:0] rst_limit;
  logic [15:0] rst_cnt;

  assign rst_limit = (restart_period < `LKS_RESTART_MIN_S) ? `LKS_RESTART_MIN_S : restart_period;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt     <= `LKS_RESTART_DEF_S;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (!restart_en || (sock_rx_valid && sock_rx_ready)) begin
        rst_cnt <= rst_limit;
      end else if (tick) begin
        if (rst_cnt <= 16'h1) begin
          restart_req <= 1'b1;
          rst_cnt     <= rst_limit;
        end else begin
          rst_cnt <= rst_cnt - 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short connection idle close

  logic [15:0] short_limit;
  logic [15:0] short_cnt;
  logic        net_busy;

  assign short_limit = (short_time < `LKS_SHORT_MIN_S) ? `LKS_SHORT_MIN_S : short_time;
  assign net_busy    = ser_rx_valid || (net_tx_valid && net_tx_ready) || sock_rx_valid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      short_cnt      <= '0;
      disconnect_req <= 1'b0;
    end else begin
      disconnect_req <= 1'b0;
      if (!short_mode || !link_any || net_busy) begin
        short_cnt <= short_limit;
      end else if (tick) begin
        if (short_cnt <= 16'h1) begin
          disconnect_req <= 1'b1;
          short_cnt      <= short_limit;
        end else begin
          short_cnt <= short_cnt - 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial transmit with socket header

  lks_tx_state_t tx_state;
  logic [1:0]    hdr_idx;
  logic          hdr_id;
  logic [7:0]    hdr_byte;

  always_comb begin
    case (hdr_idx)
      2'd0:    hdr_byte = `LKS_HDR_B0;
      2'd1:    hdr_byte = `LKS_HDR_B1;
      2'd2:    hdr_byte = `LKS_HDR_B2;
      default: hdr_byte = hdr_id ? `LKS_HDR_SOCK1 : `LKS_HDR_SOCK0;
    endcase
  end

  assign ser_tx_valid  = (tx_state == LKS_TX_HDR) || ((tx_state == LKS_TX_DATA) && sock_rx_valid);
  assign ser_tx_data   = (tx_state == LKS_TX_HDR) ? hdr_byte : sock_rx_data;
  assign sock_rx_ready = (tx_state == LKS_TX_DATA) && ser_tx_ready;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= LKS_TX_IDLE;
      hdr_idx  <= '0;
      hdr_id   <= 1'b0;
    end else begin
      case (tx_state)
        LKS_TX_IDLE: begin
          if (sock_rx_valid) begin
            hdr_id   <= sock_rx_id;
            hdr_idx  <= '0;
            tx_state <= LKS_TX_HDR;
          end
        end
        LKS_TX_HDR: begin
          if (ser_tx_ready) begin
            hdr_idx <= hdr_idx + 2'd1;
            if (hdr_idx == 2'd3) begin
              tx_state <= LKS_TX_DATA;
            end
          end
        end
        LKS_TX_DATA: begin
          if (sock_rx_valid && ser_tx_ready && sock_rx_last) begin
            tx_state <= LKS_TX_IDLE;
          end
        end
        default: tx_state <= LKS_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial idle heartbeat

  logic [15:0] ser_hb_cnt;
  logic        ser_busy;

  assign ser_busy       = ser_rx_valid || ser_tx_valid;
  assign ser_hb_sel_out = ser_hb_sel;
  assign ser_hb_hex_out = ser_hb_hex;
  assign ser_hb_len_out = (ser_hb_len > `LKS_HB_MAX_LEN) ? `LKS_HB_MAX_LEN : ser_hb_len;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ser_hb_cnt <= '0;
      ser_hb_req <= 1'b0;
    end else begin
      ser_hb_req <= 1'b0;
      if (ser_busy || ser_hb_period == 16'h0 || ser_hb_cnt == 16'h0) begin
        ser_hb_cnt <= ser_hb_period;
      end else if (tick) begin
        if (ser_hb_cnt <= 16'h1) begin
          ser_hb_req <= 1'b1;
          ser_hb_cnt <= ser_hb_period;
        end else begin
          ser_hb_cnt <= ser_hb_cnt - 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-link network heartbeat

  logic [1:0] link_prev;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_prev <= '0;
    end else begin
      link_prev <= link_up;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_net_hb
    logic [15:0] cnt;
    logic [15:0] per;
    logic [7:0]  len;

    assign per = net_hb_period[16*i +: 16];
    assign len = net_hb_len[8*i +: 8];
    assign net_hb_sel_out[2*i +: 2] = net_hb_sel[2*i +: 2];
    assign net_hb_hex_out[i]        = net_hb_hex[i];
    assign net_hb_len_out[8*i +: 8] = (len > `LKS_HB_MAX_LEN) ? `LKS_HB_MAX_LEN : len;

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cnt           <= '0;
        net_hb_req[i] <= 1'b0;
      end else begin
        net_hb_req[i] <= 1'b0;
        if (!client_mode || !link_up[i] || !link_prev[i] || per == 16'h0 || cnt == 16'h0) begin
          cnt <= per;
        end else if (tick) begin
          if (cnt <= 16'h1) begin
            net_hb_req[i] <= 1'b1;
            cnt           <= per;
          end else begin
            cnt <= cnt - 16'h1;
          end
        end
      end
    end
  end

endmodule : lks_supervisor

// ===== tb/lks_supervisor_props.sv
module lks_supervisor_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // configuration
  input wire logic        client_mode,
  input wire logic        tcp_http_client,
  input wire logic        restart_en,
  input wire logic        short_en,
  input wire logic [15:0] ser_hb_period,
  input wire logic [7:0]  ser_hb_len,
  input wire logic [7:0]  ser_hb_len_out,
  // link and streams
  input wire logic [1:0]  link_up,
  input wire logic        connect_req,
  input wire logic        disconnect_req,
  input wire logic        restart_req,
  input wire logic        ser_tx_valid,
  input wire logic        ser_tx_ready,
  input wire logic [7:0]  ser_tx_data,
  input wire logic        sock_rx_valid,
  input wire logic        sock_rx_ready,
  input wire logic [7:0]  sock_rx_data,
  input wire logic        net_tx_valid,
  input wire logic        net_tx_ready,
  input wire logic [7:0]  net_tx_data,
  input wire logic        ser_hb_req,
  input wire logic [1:0]  net_hb_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_hdr_first: assert property ($rose(ser_tx_valid) |-> ser_tx_data == 8'haa)
    else $error("serial frame does not open with aa");
  a_ser_hold: assert property (ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
    else $error("serial byte changed while stalled");
  a_data_pass: assert property (sock_rx_valid && sock_rx_ready
    |-> ser_tx_valid && ser_tx_ready && ser_tx_data == sock_rx_data)
    else $error("socket byte taken without reaching serial");
  a_conn_client: assert property (connect_req |-> $past(client_mode) ##1 !connect_req)
    else $error("connect request outside client mode or too long");
  a_restart_off: assert property ($past(!restart_en) |-> !restart_req)
    else $error("restart while disabled");
  a_short_gate: assert property ($past(!(short_en && client_mode && tcp_http_client)) |-> !disconnect_req)
    else $error("idle close without short connection");
  a_net_hb_client: assert property ($past(!client_mode) |-> net_hb_req == 2'b00)
    else $error("network heartbeat outside client mode");
  a_len_clamp: assert property ($stable(ser_hb_len) && $past(reset_n)
    |-> ser_hb_len_out == ((ser_hb_len > 8'h80) ? 8'h80 : ser_hb_len))
    else $error("heartbeat length not clamped");
  a_net_hold: assert property (net_tx_valid && !net_tx_ready |=> net_tx_valid && $stable(net_tx_data))
    else $error("network byte changed while stalled");
  a_buf_hold: assert property (!link_up[0] && $past(!link_up[0]) |-> !net_tx_valid)
    else $error("network data sent while link down");
  a_ser_hb_off: assert property (ser_hb_period == 16'h0000 && $past(ser_hb_period) == 16'h0000 |-> !ser_hb_req)
    else $error("serial heartbeat while off");
  c_header: cover property ($rose(ser_tx_valid));
  c_close: cover property (disconnect_req);
  c_restart: cover property (restart_req);
  c_net_hb: cover property (net_hb_req[1]);
endmodule : lks_supervisor_props

bind lks_supervisor lks_supervisor_props props_u (.clock, .reset_n, .client_mode, .tcp_http_client, .restart_en,
  .short_en, .ser_hb_period, .ser_hb_len, .ser_hb_len_out, .link_up, .connect_req, .disconnect_req, .restart_req,
  .ser_tx_valid, .ser_tx_ready, .ser_tx_data, .sock_rx_valid, .sock_rx_ready, .sock_rx_data, .net_tx_valid,
  .net_tx_ready, .net_tx_data, .ser_hb_req, .net_hb_req);

// ===== tb/lks_partner.sv
module lks_partner (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // link control
  input wire logic       connect_req,
  input wire logic       disconnect_req,
  input wire logic       accept,
  input wire logic       drop,
  output logic           link_up0,
  output logic           connect_fail,
  // sinks
  input wire logic       ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  output logic           ser_tx_ready,
  input wire logic       net_tx_valid,
  input wire logic [7:0] net_tx_data,
  output logic           net_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ser_q[$];
  logic [7:0] net_q[$];
  logic [2:0] stall;
  logic [1:0] pend;
  logic       req_seen, disc_seen, drop_seen;
  ////////////////////////////////////////////////////////////////////////////////
  // sample requests and collect bytes on the design's edge
  always @(posedge clock) begin
    req_seen  <= connect_req;
    disc_seen <= disconnect_req;
    drop_seen <= drop;
    if (ser_tx_valid && ser_tx_ready) ser_q.push_back(ser_tx_data);
    if (net_tx_valid && net_tx_ready) net_q.push_back(net_tx_data);
  end
  // server answers a connect after three cycles; sinks stall now and then
  always @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {stall, pend, link_up0, connect_fail, ser_tx_ready, net_tx_ready} <= '0;
    end else begin
      stall        <= stall + 3'h1;
      ser_tx_ready <= stall[1:0] != 2'h0;
      net_tx_ready <= stall != 3'h3;
      connect_fail <= 1'b0;
      if (pend != 2'h0) pend <= pend - 2'h1;
      if (pend == 2'h1) begin
        if (accept) link_up0 <= 1'b1;
        else connect_fail <= 1'b1;
      end
      if (req_seen) pend <= 2'h3;
      if (disc_seen || drop_seen) link_up0 <= 1'b0;
    end
  end
endmodule : lks_partner

// ===== tb/lks_supervisor_tb.sv
`include "lks_defs.svh"
module lks_supervisor_tb;
  import lks_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, reset_n = 0, client_mode = 0, tcp_http_client = 1, restart_en = 0, short_en = 0;
  logic [15:0] reconn_interval = 16'h0002, restart_period = 16'h0708, short_time = 16'h0002, ser_hb_period = '0;
  logic [15:0] net_hb_len = 16'h9010;
  logic [31:0] net_hb_period = '0;
  logic [7:0]  ser_hb_len = 8'hc8, ser_rx_data = '0, sock_rx_data = '0;
  logic [3:0]  net_hb_sel = 4'h6;
  logic [1:0]  net_hb_hex = 2'h1, link_up, net_hb_req, net_hb_hex_out;
  lks_hb_sel_t ser_hb_sel = LKS_HB_SERIAL_ID, ser_hb_sel_out;
  logic        clear_on_connect = 0, ser_hb_hex = 0, ser_rx_valid = 0, sock_rx_valid = 0, sock_rx_id = 0;
  logic        sock_rx_last = 0, link1 = 0, accept = 0, drop = 0, link_up0, connect_fail, connect_req;
  logic        disconnect_req, restart_req, ser_rx_ready, net_tx_valid, net_tx_ready, sock_rx_ready;
  logic        ser_tx_valid, ser_tx_ready, ser_hb_req, ser_hb_hex_out;
  logic [7:0]  net_tx_data, ser_tx_data, ser_hb_len_out;
  logic [3:0]  net_hb_sel_out;
  logic [15:0] net_hb_len_out;
  int          err_count = 0, tests_run = 0, cycles = 0, n, c0, c1;
  logic [7:0]  exp_q[12] = '{`LKS_HDR_B0, `LKS_HDR_B1, `LKS_HDR_B2, `LKS_HDR_SOCK0, 8'h11, 8'h22,
                             `LKS_HDR_B0, `LKS_HDR_B1, `LKS_HDR_B2, `LKS_HDR_SOCK1, 8'h33, 8'h44};
  assign link_up = {link1, link_up0};
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  lks_supervisor #(.TICK_CYCLES(10), .BUF_DEPTH(8)) dut_u (.clock, .reset_n, .client_mode, .tcp_http_client,
    .reconn_interval, .restart_en, .restart_period, .short_en, .short_time, .clear_on_connect, .ser_hb_period,
    .ser_hb_sel, .ser_hb_hex, .ser_hb_len, .net_hb_period, .net_hb_sel, .net_hb_hex, .net_hb_len, .link_up,
    .connect_fail, .connect_req, .disconnect_req, .restart_req, .ser_rx_valid, .ser_rx_ready, .ser_rx_data,
    .net_tx_valid, .net_tx_ready, .net_tx_data, .sock_rx_valid, .sock_rx_ready, .sock_rx_data, .sock_rx_id,
    .sock_rx_last, .ser_tx_valid, .ser_tx_ready, .ser_tx_data, .ser_hb_req, .ser_hb_sel_out, .ser_hb_hex_out,
    .ser_hb_len_out, .net_hb_req, .net_hb_sel_out, .net_hb_hex_out, .net_hb_len_out);
  lks_partner partner_u (.clock, .reset_n, .connect_req, .disconnect_req, .accept, .drop, .link_up0, .connect_fail,
    .ser_tx_valid, .ser_tx_data, .ser_tx_ready, .net_tx_valid, .net_tx_data, .net_tx_ready);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic wait_pulse(input int which, output int k);
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while ((which == 0 ? connect_req : which == 1 ? disconnect_req : which == 2 ? restart_req : ser_hb_req)
               !== 1'b1 && k < 2000);
    @(negedge clock);
  endtask : wait_pulse
  task automatic idle(input int k);
    repeat (k) @(negedge clock);
  endtask : idle
  task automatic ser_send(input logic [7:0] d);
    @(negedge clock);
    ser_rx_valid = 1;
    ser_rx_data  = d;
    do @(posedge clock); while (ser_rx_ready !== 1'b1);
    @(negedge clock);
    ser_rx_valid = 0;
    ser_rx_data  = ~d;
  endtask : ser_send
  task automatic sock_pkt(input logic id, input logic [7:0] b0, input logic [7:0] b1);
    for (int i = 0; i < 2; i++) begin
      @(negedge clock);
      {sock_rx_valid, sock_rx_id, sock_rx_data, sock_rx_last} = {1'b1, id, (i == 0) ? b0 : b1, i == 1};
      do @(posedge clock); while (sock_rx_ready !== 1'b1);
    end
    @(negedge clock);
    {sock_rx_valid, sock_rx_data} = {1'b0, ~b1};
  endtask : sock_pkt
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 12000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    idle(2);
    reset_n = 1;
    check("pulses after reset", {connect_req, disconnect_req, restart_req, ser_hb_req}, 0);
    sock_pkt(0, 8'h11, 8'h22);
    sock_pkt(1, 8'h33, 8'h44);
    idle(20);
    for (int i = 0; i < 12; i++) check("serial frame", partner_u.ser_q[i], exp_q[i]);
    $display("test headers done");
    client_mode = 1;
    for (int i = 1; i <= 10; i++) ser_send(i[7:0]);
    wait_pulse(0, n);
    wait_pulse(0, n);
    check("retry spacing", n >= 12 && n <= 30, 1);
    reconn_interval = 0;
    repeat (3) wait_pulse(0, n);
    check("fast retry", n <= 9, 1);
    accept = 1;
    idle(120);
    for (int i = 0; i < 8; i++) check("buffered byte", partner_u.net_q[i], i + 3);
    $display("test buffering done");
    {clear_on_connect, accept, drop} = 3'b101;
    idle(1);
    drop = 0;
    for (int i = 0; i < 3; i++) ser_send(8'h70);
    partner_u.net_q.delete();
    accept = 1;
    idle(60);
    check("cleared bytes", partner_u.net_q.size(), 0);
    $display("test clear done");
    {clear_on_connect, short_en} = 2'b01;
    wait_pulse(1, n);
    check("idle close", n >= 9 && n <= 30, 1);
    c0 = 0;
    repeat (60) begin
      @(posedge clock);
      #1;
      c0 += connect_req;
    end
    check("no open while empty", c0, 0);
    ser_send(8'h5a);
    idle(60);
    check("short link data", partner_u.net_q[$], 8'h5a);
    short_en = 0;
    idle(50);
    $display("test short done");
    {link1, net_hb_period} = {1'b1, 32'h00040002};
    idle(50);
    {c0, c1} = 0;
    repeat (200) begin
      @(posedge clock);
      #1;
      c0 += net_hb_req[0];
      c1 += net_hb_req[1];
    end
    check("link0 beats", c0, 10);
    check("link1 beats", c1, 5);
    check("net beat", {net_hb_sel_out, net_hb_hex_out, net_hb_len_out}, {4'h6, 2'h1, 16'h8010});
    idle(1);
    client_mode = 0;
    idle(60);
    $display("test network heartbeat done");
    ser_hb_period = 3;
    wait_pulse(3, n);
    check("serial beat delay", n >= 18 && n <= 33, 1);
    for (int s = 0; s < 3; s++) begin
      ser_hb_sel = lks_hb_sel_t'(s[1:0]);
      {ser_hb_hex, ser_hb_len} = {s[0], (s == 0) ? 8'h10 : (s == 1) ? 8'h80 : 8'hc8};
      idle(2);
      check("beat content", {ser_hb_sel_out, ser_hb_len_out}, {s[1:0], (s == 0) ? 8'h10 : 8'h80});
      check("beat hex", ser_hb_hex_out, s[0]);
    end
    ser_hb_period = 0;
    $display("test serial heartbeat done");
    restart_period = 16'h0005;
    idle(1);
    restart_en = 1;
    wait_pulse(2, n);
    check("restart delay", n >= 585 && n <= 605, 1);
    restart_en = 0;
    $display("test restart done");
    idle(5);
    summarize();
  end
endmodule : lks_supervisor_tb
